// file: rtl/lotc_map.svh
// Register offsets, field positions, reset values and timing counts of the local time counter
`ifndef LOTC_MAP_SVH
`define LOTC_MAP_SVH

`define LOTC_OFS_CTRL       8'h00
`define LOTC_OFS_PERIOD     8'h04
`define LOTC_OFS_PERR       8'h08
`define LOTC_OFS_AROLL      8'h0c
`define LOTC_OFS_AMODE      8'h10
`define LOTC_OFS_PSEC_H     8'h14
`define LOTC_OFS_PSEC_L     8'h18
`define LOTC_OFS_PNS        8'h1c
`define LOTC_OFS_CSEC_H     8'h20
`define LOTC_OFS_CSEC_L     8'h24
`define LOTC_OFS_CNS        8'h28
`define LOTC_OFS_NOW_NS     8'h2c
`define LOTC_OFS_NOW_SEC_L  8'h30

`define LOTC_BIT_CLK_SEL    0
`define LOTC_BIT_LOAD_EN    1
`define LOTC_BIT_SAVE_EN    2
`define LOTC_BIT_AUTOCLR    3
`define LOTC_BIT_OS_DIR     4
`define LOTC_BIT_OS_REQ     5
`define LOTC_BIT_HIACC      6
`define LOTC_BIT_ERR_DIR    7

`define LOTC_RST_PERIOD     8'h08
`define LOTC_RST_CTRL       8'h00

`define LOTC_NS_PER_SEC     32'h3b9aca00
`define LOTC_FS_PER_NS      21'h0f4240
`define LOTC_SYNC_LAT       10'h003

`endif

// file: rtl/lotc_pkg.sv
// Types shared by the local time counter modules
package lotc_pkg;
	typedef logic [47:0] lotc_sec_t;
	typedef logic [31:0] lotc_ns_t;
	typedef logic [9:0]  lotc_inc_t;
	typedef logic [20:0] lotc_fs_t;
endpackage : lotc_pkg

// file: rtl/lotc_strobe_sync.sv
// Load/save strobe synchroniser with rising edge pulse
`timescale 1ns/10ps
module lotc_strobe_sync import lotc_pkg::*; (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic strobe,
	output logic      rise
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;
	logic rise_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
			rise_ff <= 1'b0;
		end else begin
			meta_ff <= strobe;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
			rise_ff <= sync_ff & ~last_ff;
		end
	end
	assign rise = rise_ff;

	sequence strobe_up;
		$rose(strobe) ##1 strobe;
	endsequence
	sequence pulse_once;
		rise ##1 !rise;
	endsequence
	sync_edge_a: assert property (@(posedge ref_clk) disable iff (reset)
		strobe_up |-> ##2 pulse_once) else $error("strobe edge not seen three cycles later");
endmodule : lotc_strobe_sync

// file: rtl/lotc_top.sv
// Local time counter with APB register slave
//
// Behaviour
// - Select field chooses the counter clock source
// - Period mechanism covers 125 to 250 MHz
// - Nanoseconds advance by programmed period each cycle
// - Femtosecond accumulator adds or drops one ns
// - Error direction zero subtracts the extra nanosecond
// - Auto-adjust counter rolls over at programmed maximum
// - Rollover mode 1 adds, 2 subtracts, else none
// - Each one-shot request adjusts exactly one ns
// - Strobe edge with load enable loads preset time
// - Strobe synchronised before edge detection
// - High accuracy compensates strobe latency within 1 ns
// - This channel loads only if its enable set
// - Strobe edge with save enable captures the time
// - Auto-clear drops save enable after one save
// - Without compensation timing uncertain by one cycle
// - Counter is 48-bit seconds plus 32-bit nanoseconds
`timescale 1ns/10ps
`include "lotc_map.svh"
module lotc_top import lotc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        load_save_strobe,
	output logic             counter_clock_select,
	output logic [47:0]      time_seconds,
	output logic [31:0]      time_nanoseconds
);
	logic        ctrl_ff [8];
	logic [7:0]  period_integer_ns_ff;
	lotc_fs_t    period_error_fs_ff;
	logic [29:0] auto_adjust_rollover_ns_ff;
	logic [1:0]  auto_adjust_mode_ff;
	logic [15:0] preset_seconds_high_ff;
	logic [31:0] preset_seconds_low_ff;
	logic [29:0] preset_nanoseconds_ff;
	logic [15:0] captured_seconds_high_ff;
	logic [31:0] captured_seconds_low_ff;
	lotc_ns_t    captured_nanoseconds_ff;
	lotc_sec_t   sec_ff;
	lotc_ns_t    ns_ff;
	lotc_fs_t    acc_ff;
	lotc_ns_t    auto_ns_ff;
	logic        auto_pend_ff;
	logic        os_pend_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic        rise;
	logic        bus_wr;
	logic        load_now;
	logic        save_now;
	logic        acc_cross;
	lotc_fs_t    acc_sum;
	lotc_inc_t   base_inc;
	lotc_inc_t   inc;
	lotc_inc_t   plus_cnt;
	lotc_inc_t   minus_cnt;
	lotc_inc_t   comp;
	lotc_ns_t    auto_sum;
	logic [32:0] ns_sum;
	logic [32:0] load_sum;

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a[1:0] == 2'h0) && (a <= `LOTC_OFS_NOW_SEC_L);
	endfunction : reg_hit

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] c;
		c = 32'h0;
		for (int i = 0; i < 8; i++) begin
			c[i] = ctrl_ff[i];
		end
		c[`LOTC_BIT_OS_REQ] = 1'b0;
		case (a)
			`LOTC_OFS_CTRL:      rd_mux = c;
			`LOTC_OFS_PERIOD:    rd_mux = {24'h0, period_integer_ns_ff};
			`LOTC_OFS_PERR:      rd_mux = {11'h0, period_error_fs_ff};
			`LOTC_OFS_AROLL:     rd_mux = {2'h0, auto_adjust_rollover_ns_ff};
			`LOTC_OFS_AMODE:     rd_mux = {30'h0, auto_adjust_mode_ff};
			`LOTC_OFS_PSEC_H:    rd_mux = {16'h0, preset_seconds_high_ff};
			`LOTC_OFS_PSEC_L:    rd_mux = preset_seconds_low_ff;
			`LOTC_OFS_PNS:       rd_mux = {2'h0, preset_nanoseconds_ff};
			`LOTC_OFS_CSEC_H:    rd_mux = {16'h0, captured_seconds_high_ff};
			`LOTC_OFS_CSEC_L:    rd_mux = captured_seconds_low_ff;
			`LOTC_OFS_CNS:       rd_mux = captured_nanoseconds_ff;
			`LOTC_OFS_NOW_NS:    rd_mux = ns_ff;
			`LOTC_OFS_NOW_SEC_L: rd_mux = sec_ff[31:0];
			default:             rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	// APB slave: zero wait states, answer registered in the setup cycle
	assign bus_wr = psel & penable & pready_ff & pwrite & reg_hit(paddr);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0;
		end else begin
			pready_ff  <= psel & ~penable;
			pslverr_ff <= psel & ~penable & ~reg_hit(paddr);
			prdata_ff  <= (psel & ~penable & ~pwrite) ? rd_mux(paddr) : 32'h0;
		end
	end

	// Control bits; save enable may drop itself after a save
	for (genvar g = 0; g < 8; g++) begin : g_ctrl
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				ctrl_ff[g] <= 1'b0;
			end else if (bus_wr && paddr == `LOTC_OFS_CTRL && g != `LOTC_BIT_OS_REQ) begin
				ctrl_ff[g] <= pwdata[g];
			end else if (g == `LOTC_BIT_SAVE_EN && save_now && ctrl_ff[`LOTC_BIT_AUTOCLR]) begin
				ctrl_ff[g] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			period_integer_ns_ff       <= `LOTC_RST_PERIOD;
			period_error_fs_ff         <= 21'h0;
			auto_adjust_rollover_ns_ff <= 30'h0;
			auto_adjust_mode_ff        <= 2'h0;
			preset_seconds_high_ff     <= 16'h0;
			preset_seconds_low_ff      <= 32'h0;
			preset_nanoseconds_ff      <= 30'h0;
		end else if (bus_wr) begin
			case (paddr)
				`LOTC_OFS_PERIOD: period_integer_ns_ff       <= pwdata[7:0];
				`LOTC_OFS_PERR:   period_error_fs_ff         <= pwdata[20:0];
				`LOTC_OFS_AROLL:  auto_adjust_rollover_ns_ff <= pwdata[29:0];
				`LOTC_OFS_AMODE:  auto_adjust_mode_ff        <= pwdata[1:0];
				`LOTC_OFS_PSEC_H: preset_seconds_high_ff     <= pwdata[15:0];
				`LOTC_OFS_PSEC_L: preset_seconds_low_ff      <= pwdata;
				`LOTC_OFS_PNS:    preset_nanoseconds_ff      <= pwdata[29:0];
				default:          ;
			endcase
		end
	end

	lotc_strobe_sync u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.strobe  (load_save_strobe),
		.rise    (rise)
	);

	assign load_now = rise & ctrl_ff[`LOTC_BIT_LOAD_EN];
	assign save_now = rise & ctrl_ff[`LOTC_BIT_SAVE_EN];
	// Counter advanced this many ns since the strobe edge; added on load, removed on save when enabled
	assign comp = ctrl_ff[`LOTC_BIT_HIACC] ? 10'((`LOTC_SYNC_LAT * {2'h0, period_integer_ns_ff})) : 10'h0;

	// Increment: period, error accumulator, auto rollover and one-shot terms
	assign acc_sum   = acc_ff + period_error_fs_ff;
	assign acc_cross = acc_sum >= `LOTC_FS_PER_NS;
	assign base_inc  = (acc_cross && !ctrl_ff[`LOTC_BIT_ERR_DIR]) ? {2'h0, period_integer_ns_ff} - 10'h1 :
		{2'h0, period_integer_ns_ff} + {9'h0, acc_cross};
	assign plus_cnt  = {9'h0, auto_pend_ff && auto_adjust_mode_ff == 2'h1} +
		{9'h0, os_pend_ff && ctrl_ff[`LOTC_BIT_OS_DIR]};
	assign minus_cnt = {9'h0, auto_pend_ff && auto_adjust_mode_ff == 2'h2} +
		{9'h0, os_pend_ff && !ctrl_ff[`LOTC_BIT_OS_DIR]};
	assign inc       = (base_inc + plus_cnt > minus_cnt) ? base_inc + plus_cnt - minus_cnt : 10'h0;
	assign ns_sum    = {1'b0, ns_ff} + {23'h0, inc};
	assign load_sum  = {3'h0, preset_nanoseconds_ff} + {23'h0, comp};
	assign auto_sum  = auto_ns_ff + {22'h0, base_inc};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			acc_ff <= 21'h0;
		end else begin
			acc_ff <= acc_cross ? acc_sum - `LOTC_FS_PER_NS : acc_sum;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			auto_ns_ff   <= 32'h0;
			auto_pend_ff <= 1'b0;
		end else if (auto_adjust_rollover_ns_ff != 30'h0 && auto_sum >= {2'h0, auto_adjust_rollover_ns_ff}) begin
			auto_ns_ff   <= auto_sum - {2'h0, auto_adjust_rollover_ns_ff};
			auto_pend_ff <= 1'b1;
		end else begin
			auto_ns_ff   <= auto_sum;
			auto_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			os_pend_ff <= 1'b0;
		end else begin
			os_pend_ff <= bus_wr && paddr == `LOTC_OFS_CTRL && pwdata[`LOTC_BIT_OS_REQ];
		end
	end

	// Time of day: load has priority over the running increment
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sec_ff <= 48'h0;
			ns_ff  <= 32'h0;
		end else if (load_now) begin
			if (load_sum >= {1'b0, `LOTC_NS_PER_SEC}) begin
				ns_ff  <= 32'(load_sum - {1'b0, `LOTC_NS_PER_SEC});
				sec_ff <= {preset_seconds_high_ff, preset_seconds_low_ff} + 48'h1;
			end else begin
				ns_ff  <= load_sum[31:0];
				sec_ff <= {preset_seconds_high_ff, preset_seconds_low_ff};
			end
		end else if (ns_sum >= {1'b0, `LOTC_NS_PER_SEC}) begin
			ns_ff  <= 32'(ns_sum - {1'b0, `LOTC_NS_PER_SEC});
			sec_ff <= sec_ff + 48'h1;
		end else begin
			ns_ff  <= ns_sum[31:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			captured_seconds_high_ff <= 16'h0;
			captured_seconds_low_ff  <= 32'h0;
			captured_nanoseconds_ff  <= 32'h0;
		end else if (save_now) begin
			if (ns_ff >= {22'h0, comp}) begin
				{captured_seconds_high_ff, captured_seconds_low_ff} <= sec_ff;
				captured_nanoseconds_ff <= ns_ff - {22'h0, comp};
			end else begin
				{captured_seconds_high_ff, captured_seconds_low_ff} <= sec_ff - 48'h1;
				captured_nanoseconds_ff <= ns_ff + `LOTC_NS_PER_SEC - {22'h0, comp};
			end
		end
	end

	assign pready               = pready_ff;
	assign pslverr              = pslverr_ff;
	assign prdata               = prdata_ff;
	assign counter_clock_select = ctrl_ff[`LOTC_BIT_CLK_SEL];
	assign time_seconds         = sec_ff;
	assign time_nanoseconds     = ns_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	ns_range_a: assert property (ns_ff < `LOTC_NS_PER_SEC)
		else $error("nanoseconds out of range");
	plain_step_a: assert property (!load_now && ns_sum < {1'b0, `LOTC_NS_PER_SEC} |=>
		ns_ff == $past(ns_ff) + 32'($past(inc)) && sec_ff == $past(sec_ff))
		else $error("counter did not advance by increment");
	err_sub_a: assert property (acc_cross && !ctrl_ff[`LOTC_BIT_ERR_DIR] && plus_cnt == 10'h0 && minus_cnt == 10'h0
		&& period_integer_ns_ff > 8'h1 |-> inc == {2'h0, period_integer_ns_ff} - 10'h1)
		else $error("error correction did not subtract");
	err_add_a: assert property (acc_cross && ctrl_ff[`LOTC_BIT_ERR_DIR] && plus_cnt == 10'h0 && minus_cnt == 10'h0
		|-> inc == {2'h0, period_integer_ns_ff} + 10'h1)
		else $error("error correction did not add");
	auto_mode_a: assert property (auto_pend_ff && !acc_cross && !os_pend_ff && auto_adjust_mode_ff[0]
		== auto_adjust_mode_ff[1] |-> inc == {2'h0, period_integer_ns_ff})
		else $error("auto adjust changed increment in neutral mode");
	oneshot_a: assert property (bus_wr && paddr == `LOTC_OFS_CTRL && pwdata[`LOTC_BIT_OS_REQ] && pwdata[`LOTC_BIT_OS_DIR]
		&& !acc_cross ##1 !auto_pend_ff && !acc_cross |-> inc == {2'h0, period_integer_ns_ff} + 10'h1)
		else $error("one-shot request did not add one ns");
	load_val_a: assert property (load_now && !ctrl_ff[`LOTC_BIT_HIACC] |=>
		ns_ff == {2'h0, $past(preset_nanoseconds_ff)} && sec_ff[31:0] == $past(preset_seconds_low_ff))
		else $error("preset time not loaded");
	save_val_a: assert property (save_now && !ctrl_ff[`LOTC_BIT_HIACC] |=>
		captured_nanoseconds_ff == $past(ns_ff) && captured_seconds_low_ff == $past(sec_ff[31:0]))
		else $error("time not captured");
	autoclr_a: assert property (save_now && ctrl_ff[`LOTC_BIT_AUTOCLR] && !bus_wr |=>
		!ctrl_ff[`LOTC_BIT_SAVE_EN])
		else $error("save enable not cleared");
	auto_roll_a: assert property (auto_adjust_rollover_ns_ff != 30'h0 |=> auto_ns_ff < 32'(2 * 1024) +
		{2'h0, $past(auto_adjust_rollover_ns_ff)})
		else $error("auto adjust counter did not roll over");
	load_off_a: assert property (rise && !ctrl_ff[`LOTC_BIT_LOAD_EN] && ns_sum < {1'b0, `LOTC_NS_PER_SEC} |=>
		sec_ff == $past(sec_ff))
		else $error("time loaded without load enable");
	carry_sec_a: assert property (!load_now && ns_sum >= {1'b0, `LOTC_NS_PER_SEC} |=>
		sec_ff == $past(sec_ff) + 48'h1)
		else $error("seconds did not carry");
	hiacc_load_a: assert property (load_now && ctrl_ff[`LOTC_BIT_HIACC] |=>
		ns_ff == 32'(({2'h0, $past(preset_nanoseconds_ff)} +
		32'(`LOTC_SYNC_LAT * $past(period_integer_ns_ff))) % `LOTC_NS_PER_SEC))
		else $error("load not compensated for strobe latency");
	os_sub_a: assert property (bus_wr && paddr == `LOTC_OFS_CTRL && pwdata[`LOTC_BIT_OS_REQ]
		&& !pwdata[`LOTC_BIT_OS_DIR] ##1 !auto_pend_ff && !acc_cross && period_integer_ns_ff != 8'h0
		|-> inc == {2'h0, period_integer_ns_ff} - 10'h1)
		else $error("one-shot request did not subtract one ns");
	auto_add_a: assert property (auto_pend_ff && auto_adjust_mode_ff == 2'h1 && !acc_cross && !os_pend_ff |->
		inc == {2'h0, period_integer_ns_ff} + 10'h1)
		else $error("auto adjust did not add one ns");
	auto_sub_a: assert property (auto_pend_ff && auto_adjust_mode_ff == 2'h2 && !acc_cross && !os_pend_ff
		&& period_integer_ns_ff != 8'h0 |-> inc == {2'h0, period_integer_ns_ff} - 10'h1)
		else $error("auto adjust did not subtract one ns");
endmodule : lotc_top

// file: verif/lotc_strobe_src.sv
// Far-side timing source that raises the load/save strobe on request
`timescale 1ns/10ps
module lotc_strobe_src (
	input  wire logic ref_clk,
	input  wire logic fire,
	output logic      strobe
);
	logic [1:0] hold_ff;
	initial begin
		strobe  = 1'b0;
		hold_ff = 2'h0;
	end
	// High for three edges, then low until the next request
	always @(posedge ref_clk) begin
		if (fire) begin
			strobe  <= 1'b1;
			hold_ff <= 2'h2;
		end else if (hold_ff != 2'h0) begin
			hold_ff <= hold_ff - 2'h1;
		end else begin
			strobe <= 1'b0;
		end
	end
endmodule : lotc_strobe_src

// file: verif/tb.sv
// Self-checking bench for the local time counter
`timescale 1ns/10ps
`include "lotc_map.svh"
module tb;
	import lotc_pkg::*;
	typedef struct {logic rd; logic [31:0] data; logic err;} lotc_exp_s;
	logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, strobe, fire, clk_sel;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, pns, psl, nsx, time_ns;
	logic [15:0] psh;
	logic [47:0] time_sec, secx;
	lotc_exp_s   exq[$];
	lotc_exp_s   e;
	integer      miscompares, cmp_count, cyc, c0, per, seed, e1, e2, i;
	logic [63:0] t0;
	integer      pers[4] = '{8, 6, 5, 4};
	lotc_top dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.load_save_strobe(strobe), .counter_clock_select(clk_sel), .time_seconds(time_sec),
		.time_nanoseconds(time_ns));
	lotc_strobe_src src (.ref_clk(ref_clk), .fire(fire), .strobe(strobe));
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	task close_out;
		$display("miscompares %0d, comparisons %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	// Completed transfers are matched against the oldest expectation
	always @(posedge ref_clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (exq.size() == 0) begin
				check("spare transfer", 1, 0);
			end else begin
				e = exq.pop_front();
				check("pslverr", pslverr, e.err);
				if (e.rd)
					check("prdata", prdata, e.data);
			end
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
		integer n;
		exq.push_back('{rd: !w, data: d, err: err});
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			close_out();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [63:0] now();
		return {48'h0, time_sec[15:0]} * 64'd1000000000 + {32'h0, time_ns};
	endfunction : now
	task mark;
		t0 = now();
		c0 = cyc;
	endtask : mark
	task delta(input integer extra);
		check("ns advance", now() - t0, 64'((cyc - c0) * per + extra));
	endtask : delta
	task window(input integer extra);
		repeat (12) @(posedge ref_clk);
		mark();
		repeat (10) @(posedge ref_clk);
		delta(extra);
	endtask : window
	// Returns at the fourth edge after the strobe is first sampled high
	task strobe_go(output integer edge_no);
		integer n;
		fire <= 1'b1;
		@(posedge ref_clk);
		fire <= 1'b0;
		n = 0;
		while (strobe !== 1'b1 && n < 10) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 10) begin
			miscompares++;
			close_out();
		end
		edge_no = cyc;
		repeat (4) @(posedge ref_clk);
	endtask : strobe_go
	initial begin
		ref_clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; fire = 0;
		miscompares = 0; cmp_count = 0; cyc = 0; seed = 61; per = 8;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		apb(0, `LOTC_OFS_PERIOD, 32'(`LOTC_RST_PERIOD), 0);
		apb(0, `LOTC_OFS_CTRL, 0, 0);
		apb(0, 8'h40, 0, 1);
		apb(0, 8'h05, 0, 1);
		apb(1, 8'h44, 32'hffffffff, 1);
		for (i = 1; i >= 0; i--) begin
			apb(1, `LOTC_OFS_CTRL, i, 0);
			@(posedge ref_clk);
			check("clock select", clk_sel, i);
		end
		foreach (pers[k]) begin
			per = pers[k];
			apb(1, `LOTC_OFS_PERIOD, per, 0);
			window(0);
		end
		per = 6;
		apb(1, `LOTC_OFS_PERIOD, per, 0);
		apb(1, `LOTC_OFS_PERR, 32'd100000, 0);
		window(-1);
		apb(1, `LOTC_OFS_CTRL, 32'h80, 0);
		window(1);
		apb(1, `LOTC_OFS_PERR, 0, 0);
		apb(1, `LOTC_OFS_CTRL, 0, 0);
		per = 8;
		apb(1, `LOTC_OFS_PERIOD, per, 0);
		apb(1, `LOTC_OFS_AROLL, 32'd80, 0);
		for (i = 0; i < 4; i++) begin
			apb(1, `LOTC_OFS_AMODE, i, 0);
			window(i == 1 ? 1 : (i == 2 ? -1 : 0));
		end
		apb(1, `LOTC_OFS_AROLL, 0, 0);
		repeat (12) @(posedge ref_clk);
		for (i = 0; i < 2; i++) begin
			mark();
			apb(1, `LOTC_OFS_CTRL, 32'h20 | (i << 4), 0);
			repeat (3) @(posedge ref_clk);
			delta(i == 1 ? 1 : -1);
			apb(0, `LOTC_OFS_CTRL, i << 4, 0);
		end
		psh = 16'($random(seed));
		psl = $random(seed);
		pns = 32'd999999960 + ($unsigned($random(seed)) % 16);
		apb(1, `LOTC_OFS_PSEC_H, {16'h0, psh}, 0);
		apb(1, `LOTC_OFS_PSEC_L, psl, 0);
		apb(1, `LOTC_OFS_PNS, pns, 0);
		apb(1, `LOTC_OFS_CTRL, 0, 0);
		strobe_go(e1);
		check("unloaded seconds", time_sec, 0);
		apb(1, `LOTC_OFS_CTRL, 32'h42, 0);
		strobe_go(e1);
		check("loaded seconds", time_sec, {psh, psl});
		check("loaded ns", time_ns, pns + 24);
		repeat (3) @(posedge ref_clk);
		check("carried seconds", time_sec, {psh, psl} + 48'h1);
		check("wrapped ns", time_ns, pns + 48 - `LOTC_NS_PER_SEC);
		apb(1, `LOTC_OFS_CTRL, 32'h0e, 0);
		strobe_go(e2);
		check("reloaded seconds", time_sec, {psh, psl});
		check("reloaded ns", time_ns, pns);
		nsx  = pns + 24 + 8 * (e2 - e1 - 1);
		secx = {psh, psl};
		if (nsx >= `LOTC_NS_PER_SEC) begin
			nsx  = nsx - `LOTC_NS_PER_SEC;
			secx = secx + 48'h1;
		end
		apb(0, `LOTC_OFS_CSEC_H, {16'h0, secx[47:32]}, 0);
		apb(0, `LOTC_OFS_CSEC_L, secx[31:0], 0);
		apb(0, `LOTC_OFS_CNS, nsx, 0);
		apb(0, `LOTC_OFS_CTRL, 32'h0a, 0);
		repeat (2) @(posedge ref_clk);
		close_out();
	end
endmodule : tb
